// >>> rtl/pci_pin_change_interrupt.sv
// pin change interrupt: edge enables, sticky flags, summary and wake
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none

module pci_pin_change_interrupt
  import pci_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [39:0] pins,
  output logic change_irq,
  output logic wake_request,
  output logic change_irq_summary_flag
);

  `include "pci_defines.svh"

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------

  // port number of an address; the core control word maps to port 5
  function automatic pci_port_idx_t addr_port(input logic [7:0] a);
    addr_port = a[6:4];
  endfunction : addr_port

  // word kind of an address inside its port
  function automatic pci_kind_t addr_kind(input logic [7:0] a);
    pci_kind_t k;
    k = PCI_KIND_RISE;
    if (a == `PCI_CORE_CTRL_ADDR)
    begin
      k = PCI_KIND_CTRL;
    end
    else if (a[3:0] == 4'(`PCI_OFS_FALL))
    begin
      k = PCI_KIND_FALL;
    end
    else if (a[3:0] == 4'(`PCI_OFS_FLAGS))
    begin
      k = PCI_KIND_FLAGS;
    end
    addr_kind = k;
  endfunction : addr_kind

  // true when the address names a real register
  function automatic logic addr_ok(input logic [7:0] a);
    logic ok;
    ok = 1'b0;
    if (a == `PCI_CORE_CTRL_ADDR)
    begin
      ok = 1'b1;
    end
    else if (a[7] == 1'b0 && a[6:4] < 3'(`PCI_NUM_PORTS))
    begin
      ok = (a[3:0] == 4'(`PCI_OFS_RISE)) || (a[3:0] == 4'(`PCI_OFS_FALL))
        || (a[3:0] == 4'(`PCI_OFS_FLAGS));
    end
    addr_ok = ok;
  endfunction : addr_ok

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  pci_port_t rise_en [`PCI_NUM_PORTS];
  pci_port_t fall_en [`PCI_NUM_PORTS];
  pci_port_t flags [`PCI_NUM_PORTS];
  pci_port_t edge_hit [`PCI_NUM_PORTS];
  logic change_irq_master_enable;
  pci_apb_state_t apb_state;
  pci_apb_state_t next_apb_state;
  logic wr_fire;
  logic any_flag;
  logic [31:0] next_rdata;
  pci_port_idx_t req_port;
  pci_kind_t req_kind;

  // ----------------------------------------------------------------
  // bus slave: no wait state, answer registered in the setup cycle
  // ----------------------------------------------------------------
  assign req_port = addr_port(paddr);
  assign req_kind = addr_kind(paddr);

  // setup arms the answer; the access edge with pready ends it
  always_comb
  begin
    next_apb_state = apb_state;
    unique case (apb_state)
      PCI_IDLE:
      begin
        if (psel && !penable)
        begin
          next_apb_state = PCI_ANSWER;
        end
      end
      PCI_ANSWER:
      begin
        next_apb_state = PCI_IDLE;
      end
      default:
      begin
        next_apb_state = PCI_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      apb_state <= PCI_IDLE;
    end
    else
    begin
      apb_state <= next_apb_state;
    end
  end

  // pready straight from a flop, high for exactly the access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
    end
    else
    begin
      pready <= (apb_state == PCI_IDLE) && psel && !penable;
    end
  end

  // unmapped addresses answer with an error and write nothing
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pslverr <= 1'b0;
    end
    else if ((apb_state == PCI_IDLE) && psel && !penable)
    begin
      pslverr <= !addr_ok(paddr);
    end
    else
    begin
      pslverr <= 1'b0;
    end
  end

  // a write lands only on the access edge that sees pready
  assign wr_fire = psel && penable && pready && pwrite && !pslverr;

  // read mux; unused upper bits read as zero
  always_comb
  begin
    next_rdata = `PCI_RESET_DATA;
    if (addr_ok(paddr))
    begin
      unique case (req_kind)
        PCI_KIND_RISE:
        begin
          next_rdata[7:0] = rise_en[req_port];
        end
        PCI_KIND_FALL:
        begin
          next_rdata[7:0] = fall_en[req_port];
        end
        PCI_KIND_FLAGS:
        begin
          next_rdata[7:0] = flags[req_port];
        end
        PCI_KIND_CTRL:
        begin
          next_rdata[`PCI_CTRL_MIE_BIT] = change_irq_master_enable;
          next_rdata[`PCI_CTRL_SUM_BIT] = change_irq_summary_flag;
        end
      endcase
    end
  end

  // read data captured in setup and held through the access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= `PCI_RESET_DATA;
    end
    else if ((apb_state == PCI_IDLE) && psel && !penable && !pwrite)
    begin
      prdata <= next_rdata;
    end
    else if (pready)
    begin
      prdata <= `PCI_RESET_DATA;
    end
  end

  // ----------------------------------------------------------------
  // control bits
  // ----------------------------------------------------------------

  // master enable lives in byte lane 0 of the core control word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      change_irq_master_enable <= 1'b0;
    end
    else if (wr_fire && req_kind == PCI_KIND_CTRL && pstrb[0])
    begin
      change_irq_master_enable <= pwdata[`PCI_CTRL_MIE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // per-port detectors, enables and sticky flags
  // ----------------------------------------------------------------
  genvar gp;
  generate
    for (gp = 0; gp < `PCI_NUM_PORTS; gp++)
    begin : g_port

      // every pin has both detectors, gated only by its enables once primed
      pci_edge_detect u_edge
      (
        .pclk(pclk),
        .presetn(presetn),
        .pin(pins[gp*8 +: 8]),
        .rise_en(rise_en[gp]),
        .fall_en(fall_en[gp]),
        .edge_hit(edge_hit[gp])
      );

      // rising edge enable word
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          rise_en[gp] <= `PCI_RESET_PORT;
        end
        else if (wr_fire && req_kind == PCI_KIND_RISE && req_port == 3'(gp)
          && pstrb[0])
        begin
          rise_en[gp] <= pwdata[7:0];
        end
      end

      // falling edge enable word
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          fall_en[gp] <= `PCI_RESET_PORT;
        end
        else if (wr_fire && req_kind == PCI_KIND_FALL && req_port == 3'(gp)
          && pstrb[0])
        begin
          fall_en[gp] <= pwdata[7:0];
        end
      end

      // flags set regardless of master enable; an edge in the write
      // cycle is or-ed in after the written value, so it always wins
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          flags[gp] <= `PCI_RESET_PORT;
        end
        else if (wr_fire && req_kind == PCI_KIND_FLAGS && req_port == 3'(gp)
          && pstrb[0])
        begin
          flags[gp] <= pwdata[7:0] | edge_hit[gp];
        end
        else
        begin
          flags[gp] <= flags[gp] | edge_hit[gp];
        end
      end

    end
  endgenerate

  // ----------------------------------------------------------------
  // summary, request and wake
  // ----------------------------------------------------------------

  // wide or over every flag of every port
  always_comb
  begin
    any_flag = 1'b0;
    for (int i = 0; i < `PCI_NUM_PORTS; i++)
    begin
      any_flag = any_flag | (|flags[i]);
    end
  end

  // summary follows the flags one cycle later, as a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      change_irq_summary_flag <= 1'b0;
    end
    else
    begin
      change_irq_summary_flag <= any_flag;
    end
  end

  // request held as long as any flag stands and the master is on
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      change_irq <= 1'b0;
    end
    else
    begin
      change_irq <= any_flag && change_irq_master_enable;
    end
  end

  // wake uses the same term; the core clock keeps running in sleep
  // for this block, so a sleep edge is in the flags before wake
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wake_request <= 1'b0;
    end
    else
    begin
      wake_request <= any_flag && change_irq_master_enable;
    end
  end

endmodule : pci_pin_change_interrupt

`default_nettype wire

// >>> rtl/pci_defines.svh
// constants for the pin change interrupt block: geometry, offsets, fields
`ifndef PCI_DEFINES_SVH
`define PCI_DEFINES_SVH

// ----------------------------------------------------------------
// geometry
// ----------------------------------------------------------------
`define PCI_NUM_PORTS 5
`define PCI_PORT_W 8
`define PCI_NUM_PINS 40
`define PCI_ADDR_W 8
`define PCI_DATA_W 32

// ----------------------------------------------------------------
// register map: port p at p*16, three words each
// ----------------------------------------------------------------
`define PCI_PORT_STRIDE 8'h10
`define PCI_OFS_RISE 8'h00
`define PCI_OFS_FALL 8'h04
`define PCI_OFS_FLAGS 8'h08
`define PCI_CORE_CTRL_ADDR 8'h50

// ----------------------------------------------------------------
// core interrupt control fields and reset values
// ----------------------------------------------------------------
`define PCI_CTRL_MIE_BIT 0
`define PCI_CTRL_SUM_BIT 1
`define PCI_RESET_PORT 8'h00
`define PCI_RESET_DATA 32'h0000_0000

// ----------------------------------------------------------------
// timing: synchroniser settle cycles before edges are believed
// ----------------------------------------------------------------
`define PCI_SETTLE_CYCLES 2'h3

`endif

// >>> rtl/pci_pkg.sv
// types shared by the pin change interrupt block
package pci_pkg;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef logic [7:0] pci_port_t;
  typedef logic [2:0] pci_port_idx_t;

  // which word of a port a bus address selects
  typedef enum logic [1:0]
  {
    PCI_KIND_RISE = 2'h0,
    PCI_KIND_FALL = 2'h1,
    PCI_KIND_FLAGS = 2'h2,
    PCI_KIND_CTRL = 2'h3
  } pci_kind_t;

  // bus slave phase, gray along idle -> answer -> idle
  typedef enum logic [1:0]
  {
    PCI_IDLE = 2'b00,
    PCI_ANSWER = 2'b01
  } pci_apb_state_t;

endpackage : pci_pkg

// >>> rtl/pci_edge_detect.sv
// per-port input synchroniser and rising/falling edge detector
`timescale 1ns/1ns
`default_nettype none

module pci_edge_detect
  import pci_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire pci_pkg::pci_port_t pin,
  input wire pci_pkg::pci_port_t rise_en,
  input wire pci_pkg::pci_port_t fall_en,
  output pci_pkg::pci_port_t edge_hit
);

  `include "pci_defines.svh"

  pci_port_t sync_a;
  pci_port_t sync_b;
  pci_port_t prev;
  logic [1:0] settle;
  logic primed;

  // two flops before anything looks at the pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_a <= `PCI_RESET_PORT;
      sync_b <= `PCI_RESET_PORT;
      prev <= `PCI_RESET_PORT;
    end
    else
    begin
      sync_a <= pin;
      sync_b <= sync_a;
      prev <= sync_b;
    end
  end

  // hold off detection until the chain holds real pin levels,
  // so a pin that is high at reset release is no rising edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      settle <= 2'h0;
      primed <= 1'b0;
    end
    else if (settle != `PCI_SETTLE_CYCLES)
    begin
      settle <= settle + 2'h1;
    end
    else
    begin
      primed <= 1'b1;
    end
  end

  // one-cycle pulse per enabled edge; both enables give both edges
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      edge_hit <= `PCI_RESET_PORT;
    end
    else if (primed)
    begin
      edge_hit <= (sync_b & ~prev & rise_en) | (~sync_b & prev & fall_en);
    end
    else
    begin
      edge_hit <= `PCI_RESET_PORT;
    end
  end

endmodule : pci_edge_detect

`default_nettype wire

// >>> tb/pci_pin_source.sv
// far-side model: external pins driven onto the block
`timescale 1ns/1ns
`default_nettype none

module pci_pin_source
(
  input wire logic pclk,
  input wire logic [39:0] level,
  output logic [39:0] pins
);
  // ------------------------------------------
  // pin drive
  // ------------------------------------------
  // clean edges only, moved on a clock edge
  initial pins = 40'h0;
  always @(posedge pclk)
    pins <= level;
endmodule : pci_pin_source

`default_nettype wire

// >>> tb/pci_irq_monitor.sv
// assertions on the ports of the pin change interrupt block
`timescale 1ns/1ns
`default_nettype none

module pci_irq_monitor
  import pci_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic change_irq,
  input wire logic wake_request,
  input wire logic change_irq_summary_flag
);
  // ------------------------------------------
  // helpers
  // ------------------------------------------
  logic acc_wr;
  logic fl_wr;
  logic mie_q;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // completed writes, and those that hit a flag word
  assign acc_wr = psel && penable && pready && pwrite && pstrb[0];
  assign fl_wr = acc_wr && paddr[3:0] == 4'h8 && paddr < 8'h50;
  // shadow of the master enable, set at the write edge
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      mie_q <= 1'b0;
    else if (acc_wr && paddr == 8'h50)
      mie_q <= pwdata[0];
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  // ------------------------------------------
  // assertions
  // ------------------------------------------
  AST_APB_ANSWER:
    assert property (s_setup |=> s_answer) else $error("no one-cycle answer");
  AST_READY_ACCESS:
    assert property (pready |-> psel && penable) else $error("ready outside access");
  AST_ERR_READY:
    assert property (pslverr |-> pready) else $error("error without ready");
  AST_RDATA_IDLE:
    assert property (!pready |-> prdata == 32'h0) else $error("read data while idle");
  AST_RDATA_HIGH:
    assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
  AST_IRQ_GATE:
    assert property (change_irq == (change_irq_summary_flag && $past(mie_q)))
      else $error("request not summary and enable");
  AST_WAKE:
    assert property (wake_request == change_irq) else $error("wake differs from request");
  AST_WAKE_FLAGGED:
    assert property (wake_request |-> change_irq_summary_flag)
      else $error("wake without a recorded flag");
  AST_FLAG_STICKY:
    assert property ($fell(change_irq_summary_flag) |-> $past(fl_wr, 2))
      else $error("summary fell without flag write");
endmodule : pci_irq_monitor

bind pci_pin_change_interrupt pci_irq_monitor i_pci_irq_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .change_irq(change_irq), .wake_request(wake_request),
  .change_irq_summary_flag(change_irq_summary_flag));

`default_nettype wire

// >>> tb/test_pin_change_interrupt.sv
// self-checking bench for the pin change interrupt block
`timescale 1ns/1ns
`default_nettype none

module test_pin_change_interrupt;
  import pci_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic change_irq, wake_request, change_irq_summary_flag;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [39:0] lvl, pins;
  int error_cnt, checks_done, cyc, n;

  // ------------------------------------------
  // design and far side
  // ------------------------------------------
  pci_pin_change_interrupt i_pci_pin_change_interrupt (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins), .change_irq(change_irq),
    .wake_request(wake_request), .change_irq_summary_flag(change_irq_summary_flag));
  pci_pin_source i_pci_pin_source (.pclk(pclk), .level(lvl), .pins(pins));

  // ------------------------------------------
  // helpers
  // ------------------------------------------
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask : chk

  // one apb transfer; holds until ready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task final_report;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  // ------------------------------------------
  // scenarios
  // ------------------------------------------
  // reset values, unused word and past the map
  task t_map;
    logic [7:0] a;
    for (int i = 0; i < 17; i++)
    begin
      a = (i < 15) ? 8'(i / 3 * 16 + i % 3 * 4) : ((i == 15) ? 8'h50 : 8'h0C);
      apb(1'b0, a, 32'h0);
      chk("reset value", 32'h0, rd);
      chk("slave error", 32'(i == 16), 32'(er));
    end
    apb(1'b1, 8'h54, 32'h1);
    chk("unmapped write error", 32'h1, 32'(er));
    apb(1'b0, 8'h50, 32'h0);
    chk("control unchanged", 32'h0, rd);
    // a write with lane 0 strobe low must change nothing
    pstrb <= 4'hE;
    apb(1'b1, 8'h50, 32'h1);
    pstrb <= 4'hF;
    apb(1'b0, 8'h50, 32'h0);
    chk("lane 0 strobe off", 32'h0, rd);
  endtask : t_map

  // every port, rise / fall / both, master off
  task t_edges;
    logic [7:0] b;
    int m;
    for (int p = 0; p < 5; p++)
    begin
      b = 8'(p * 16);
      m = p % 3 + 1;
      apb(1'b1, b, (m & 1) ? 32'h1 << p : 32'h0);
      apb(1'b1, b + 8'h4, (m & 2) ? 32'h1 << p : 32'h0);
      lvl[8 * p + p] <= 1'b1;
      repeat (12) @(posedge pclk);
      apb(1'b0, b + 8'h8, 32'h0);
      chk("rise flag", (m & 1) ? 32'h1 << p : 32'h0, rd);
      chk("request off", 32'h0, 32'(change_irq));
      apb(1'b1, b + 8'h8, 32'h0);
      lvl[8 * p + p] <= 1'b0;
      repeat (12) @(posedge pclk);
      apb(1'b0, b + 8'h8, 32'h0);
      chk("fall flag", (m & 2) ? 32'h1 << p : 32'h0, rd);
      apb(1'b1, b + 8'h8, 32'h0);
      apb(1'b1, b, 32'h0);
      apb(1'b1, b + 8'h4, 32'h0);
    end
  endtask : t_edges

  // summary, master gating, masked clear
  task t_master;
    logic [31:0] seen;
    apb(1'b1, 8'h00, 32'h1);
    lvl[0] <= 1'b1;
    repeat (12) @(posedge pclk);
    chk("request gated", 32'h0, 32'(change_irq));
    apb(1'b0, 8'h50, 32'h0);
    chk("summary bit", 32'h2, rd);
    chk("summary port", 32'h1, 32'(change_irq_summary_flag));
    apb(1'b1, 8'h50, 32'h1);
    repeat (2) @(posedge pclk);
    chk("request on", 32'h1, 32'(change_irq));
    chk("wake", 32'h1, 32'(wake_request));
    apb(1'b0, 8'h08, 32'h0);
    seen = rd;
    apb(1'b0, 8'h08, 32'h0);
    apb(1'b1, 8'h08, rd & ~seen);
    repeat (3) @(posedge pclk);
    chk("request cleared", 32'h0, 32'(change_irq));
    chk("summary cleared", 32'h0, 32'(change_irq_summary_flag));
    lvl[0] <= 1'b0;
    repeat (12) @(posedge pclk);
  endtask : t_master

  // edge landing before, on and after the clearing write
  task t_collide;
    lvl[0] <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (change_irq_summary_flag !== 1'b1 && n < 20);
    chk("edge latency sane", 32'h1, 32'(n >= 6 && n < 20));
    apb(1'b1, 8'h08, 32'h0);
    lvl[0] <= 1'b0;
    repeat (12) @(posedge pclk);
    for (int j = 0; j < 3; j++)
    begin
      lvl[0] <= 1'b1;
      repeat (n - 6 + j) @(posedge pclk);
      apb(1'b1, 8'h08, 32'h0);
      apb(1'b0, 8'h08, 32'h0);
      chk("flag after clear", 32'(j < 2), rd);
      apb(1'b1, 8'h08, 32'h0);
      lvl[0] <= 1'b0;
      repeat (12) @(posedge pclk);
    end
  endtask : t_collide

  // mid-run reset clears flags, enables and request; held pin is no edge
  task t_reset;
    lvl[0] <= 1'b1;
    repeat (12) @(posedge pclk);
    chk("request before reset", 32'h1, 32'(change_irq));
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk("request after reset", 32'h0, 32'(change_irq));
    chk("summary after reset", 32'h0, 32'(change_irq_summary_flag));
    apb(1'b0, 8'h50, 32'h0);
    chk("control after reset", 32'h0, rd);
    apb(1'b1, 8'h00, 32'h1);
    repeat (12) @(posedge pclk);
    apb(1'b0, 8'h08, 32'h0);
    chk("no edge from held pin", 32'h0, rd);
    lvl[0] <= 1'b0;
    repeat (12) @(posedge pclk);
  endtask : t_reset

  // ------------------------------------------
  // clock, timeout and main sequence
  // ------------------------------------------
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // hang guard, far beyond the few hundred cycles used
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      final_report;
    end
  end

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, lvl, cyc} = '0;
    pstrb = 4'hF;
    presetn = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) @(posedge pclk);
    t_map;
    t_edges;
    t_master;
    t_collide;
    t_reset;
    final_report;
  end
endmodule : test_pin_change_interrupt

`default_nettype wire
